// File: daq_command_register.sv
// Notes on behaviour
// - No reset value; contents survive board reset, software initialises.
// - Bit 15 drives the calibration memory chip select while set.
// - Bit 14 is the serial data bit shared by memory and both DACs.
// - Rising bit 13 shifts data into DACs, and memory only when selected.
// - DACs always shift but outputs change only on their own load strobe.
// - Bit 12 set: counter 1 steps the sequence; clear: every conversion.
// - Bit 11 enables about half an LSB of dither noise.
// - Bit 10 set suppresses every A/D conversion.
// - Bit 9 set: trigger refused until in-progress flag is acknowledged.
// - Bit 8 enables acquisition; clear ignores both trigger sources.
// - Bit 7 with acquisition enabled scans channels from config memory.
// - Scan clock output enabled only while bit 7 is set.
// - Bit 6 set with bits 7 and 8: one sequence per scan interval; clear: back to back.
// - Bit 5 clear: 16-bit count; set: counters 4 and 5 cascaded.
// - Bit 4 set: bus trigger only; local start and external ignored.
`default_nettype none
module daq_command_register #(
  parameter int DAC_W = daq_cmd_pkg::CAL_DAC_W
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic WR_EN,
  input wire logic [daq_cmd_pkg::ADDR_W-1:0] WR_ADDR,
  input wire logic [daq_cmd_pkg::DATA_W-1:0] WR_DATA,
  input wire logic [1:0] CAL_DAC_LOAD,
  input wire logic START_STROBE,
  input wire logic EXTERNAL_TRIGGER_IN_N,
  input wire logic BUS_TRIGGER_IN,
  input wire logic SEQUENCE_DONE,
  input wire logic PROGRESS_ACK,
  input wire logic CONVERT_REQ,
  output logic CAL_MEMORY_SELECT,
  output logic SERIAL_DATA_BIT,
  output logic SERIAL_CLOCK,
  output logic MEMORY_SHIFT_PULSE,
  output logic DAC_SHIFT_PULSE,
  output logic [DAC_W-1:0] CAL_DAC0_VALUE,
  output logic [DAC_W-1:0] CAL_DAC1_VALUE,
  output logic SEQUENCE_BY_COUNTER,
  output logic DITHER_ENABLE,
  output logic CONVERT_GO,
  output logic ACQ_TRIGGER,
  output logic ACQUISITION_IN_PROGRESS,
  output logic SCAN_ACTIVE,
  output logic SCAN_CLOCK_OUT_OE,
  output logic INTERVAL_SCAN,
  output logic WIDE_COUNT_SELECT
);
  // ----------------------------------------
  // Command register
  // ----------------------------------------
  daq_cmd_pkg::cmd_t cmd;
  daq_cmd_pkg::cmd_t wdata;
  logic hit;
  logic clk_rise;
  logic [DAC_W-1:0] dac_shift [2];

  assign wdata = daq_cmd_pkg::cmd_t'(WR_DATA);
  assign hit = WR_EN && (WR_ADDR == daq_cmd_pkg::CMD_ONE_OFFSET);
  assign clk_rise = hit && wdata.serial_clock && !cmd.serial_clock;

  // No reset on purpose: contents must survive a board reset
  always_ff @(posedge CORE_CLK) begin
    if (hit) begin
      cmd <= wdata;
    end
  end

  // ----------------------------------------
  // Serial calibration port
  // ----------------------------------------
  // Pins follow the stored bits one cycle after the write
  always_ff @(posedge CORE_CLK) begin
    CAL_MEMORY_SELECT <= cmd.cal_memory_select;
    SERIAL_DATA_BIT <= cmd.serial_data_bit;
    SERIAL_CLOCK <= cmd.serial_clock;
  end

  // Shift strobes, memory one gated by its select
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      DAC_SHIFT_PULSE <= 1'b0;
      MEMORY_SHIFT_PULSE <= 1'b0;
    end else begin
      DAC_SHIFT_PULSE <= clk_rise;
      MEMORY_SHIFT_PULSE <= clk_rise && wdata.cal_memory_select;
    end
  end

  // Per-DAC shift register and held output
  for (genvar d = 0; d < 2; d++) begin : g_dac
    always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
        dac_shift[d] <= '0;
      end else if (clk_rise) begin
        dac_shift[d] <= {dac_shift[d][DAC_W-2:0], wdata.serial_data_bit};
      end
    end
  end

  // Outputs move only on the load strobe, never on shifting
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      CAL_DAC0_VALUE <= '0;
      CAL_DAC1_VALUE <= '0;
    end else begin
      if (CAL_DAC_LOAD[0]) begin
        CAL_DAC0_VALUE <= dac_shift[0];
      end
      if (CAL_DAC_LOAD[1]) begin
        CAL_DAC1_VALUE <= dac_shift[1];
      end
    end
  end

  // ----------------------------------------
  // Sequencer configuration
  // ----------------------------------------
  always_ff @(posedge CORE_CLK) begin
    SEQUENCE_BY_COUNTER <= cmd.sequence_by_counter;
    DITHER_ENABLE <= cmd.dither_enable;
    SCAN_ACTIVE <= cmd.multi_channel_enable
      && cmd.acquisition_enable;
    SCAN_CLOCK_OUT_OE <= cmd.multi_channel_enable;
    INTERVAL_SCAN <= cmd.interval_scan_select && cmd.multi_channel_enable
      && cmd.acquisition_enable;
    WIDE_COUNT_SELECT <= cmd.wide_count_select;
  end

  // Conversion gate; a held request is simply dropped
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      CONVERT_GO <= 1'b0;
    end else begin
      CONVERT_GO <= CONVERT_REQ && !cmd.conversion_inhibit;
    end
  end

  // ----------------------------------------
  // Trigger path
  // ----------------------------------------
  logic [1:0] ext_sync;
  logic [1:0] bus_sync;
  logic ext_last;
  logic bus_last;
  logic ext_fall;
  logic bus_rise;
  logic local_trig;
  logic trig_ok;
  daq_cmd_pkg::acq_state_t state;

  // Two-flop synchronisers on the connector pins
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ext_sync <= 2'h3;
      bus_sync <= 2'h0;
      ext_last <= 1'b1;
      bus_last <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], EXTERNAL_TRIGGER_IN_N};
      bus_sync <= {bus_sync[0], BUS_TRIGGER_IN};
      ext_last <= ext_sync[1];
      bus_last <= bus_sync[1];
    end
  end

  assign ext_fall = ext_last && !ext_sync[1];
  assign bus_rise = bus_sync[1] && !bus_last;
  assign local_trig = START_STROBE || ext_fall;
  // Refused while running, or while unacknowledged under retrigger block
  assign trig_ok = cmd.acquisition_enable
    && (cmd.bus_trigger_select ? bus_rise : local_trig)
    && (state == daq_cmd_pkg::ACQ_IDLE)
    && !(cmd.retrigger_block && ACQUISITION_IN_PROGRESS);

  // Run state: one sequence at a time
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      state <= daq_cmd_pkg::ACQ_IDLE;
    end else begin
      case (state)
        daq_cmd_pkg::ACQ_IDLE: begin
          if (trig_ok) begin
            state <= daq_cmd_pkg::ACQ_RUNNING;
          end
        end
        daq_cmd_pkg::ACQ_RUNNING: begin
          if (SEQUENCE_DONE) begin
            state <= daq_cmd_pkg::ACQ_IDLE;
          end
        end
        default: begin
          state <= daq_cmd_pkg::ACQ_IDLE;
        end
      endcase
    end
  end

  // Trigger pulse and in-progress flag; a new start beats the ack
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ACQ_TRIGGER <= 1'b0;
      ACQUISITION_IN_PROGRESS <= 1'b0;
    end else begin
      ACQ_TRIGGER <= trig_ok;
      if (trig_ok) begin
        ACQUISITION_IN_PROGRESS <= 1'b1;
      end else if (PROGRESS_ACK) begin
        ACQUISITION_IN_PROGRESS <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SELECT_FOLLOWS: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    hit |-> ##2 CAL_MEMORY_SELECT == $past(WR_DATA[15], 2))
    else $error("memory select does not follow bit 15");
  AST_DATA_FOLLOWS: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    hit |-> ##2 SERIAL_DATA_BIT == $past(WR_DATA[14], 2))
    else $error("serial data does not follow bit 14");
  AST_MEM_GATED: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    MEMORY_SHIFT_PULSE |-> DAC_SHIFT_PULSE && $past(WR_DATA[15]))
    else $error("memory shifted while not selected");
  AST_DAC_HOLD: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    !$past(CAL_DAC_LOAD[0]) |-> $stable(CAL_DAC0_VALUE))
    else $error("DAC 0 output moved without load");
  AST_DAC1_HOLD: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    !$past(CAL_DAC_LOAD[1]) |-> $stable(CAL_DAC1_VALUE))
    else $error("DAC 1 output moved without load");
  AST_INHIBIT: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    CONVERT_GO |-> $past(CONVERT_REQ) && !$past(cmd.conversion_inhibit))
    else $error("conversion passed while inhibited");
  AST_RETRIG: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    ACQ_TRIGGER |-> !$past(ACQUISITION_IN_PROGRESS && cmd.retrigger_block))
    else $error("trigger taken before acknowledge");
  AST_ENABLE: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    ACQ_TRIGGER |-> $past(cmd.acquisition_enable))
    else $error("trigger while acquisition disabled");
  AST_SCAN_ACTIVE: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    hit |-> ##2 SCAN_ACTIVE == &$past(WR_DATA[8:7], 2))
    else $error("scan active does not follow bits 7 and 8");
  AST_SCAN_CLK: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    hit |-> ##2 SCAN_CLOCK_OUT_OE == $past(WR_DATA[7], 2))
    else $error("scan clock enable wrong");
  AST_BUS_ONLY: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    ACQ_TRIGGER && $past(cmd.bus_trigger_select) |-> $past(bus_rise))
    else $error("local trigger used in bus mode");
  AST_WIDE: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    hit |-> ##2 WIDE_COUNT_SELECT == $past(WR_DATA[5], 2))
    else $error("count width does not follow bit 5");

  COV_TRIGGER: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    ACQ_TRIGGER ##[1:50] SEQUENCE_DONE);
  COV_MEM_SHIFT: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    MEMORY_SHIFT_PULSE);
  COV_DAC_LOAD: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    DAC_SHIFT_PULSE ##[1:50] CAL_DAC_LOAD[1]);
endmodule
`default_nettype wire

// File: daq_cmd_pkg.sv
`default_nettype none
package daq_cmd_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] CMD_ONE_OFFSET = 5'h00;
  localparam int DATA_W = 16;
  localparam int CAL_DAC_W = 8;
  localparam logic [1:0] DAC_LOAD_NONE = 2'h0;
  localparam logic [3:0] RESERVED_ZERO = 4'h0;

  // Field layout of the command register, bit 15 first
  typedef struct packed {
    logic cal_memory_select;
    logic serial_data_bit;
    logic serial_clock;
    logic sequence_by_counter;
    logic dither_enable;
    logic conversion_inhibit;
    logic retrigger_block;
    logic acquisition_enable;
    logic multi_channel_enable;
    logic interval_scan_select;
    logic wide_count_select;
    logic bus_trigger_select;
    logic [3:0] reserved;
  } cmd_t;

  typedef enum logic [0:0] {ACQ_IDLE, ACQ_RUNNING} acq_state_t;
endpackage
`default_nettype wire

// File: cal_serial_model.sv
`default_nettype none
module cal_serial_model (
  input wire logic clk,
  input wire logic memory_select,
  input wire logic serial_data,
  input wire logic memory_shift,
  input wire logic dac_shift
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] memory_word = 16'h0000;
  int memory_bits = 0;
  int dac_bits = 0;
  // Every shift is counted so a stray memory pulse is still seen
  always @(posedge clk) begin
    if (memory_shift) begin
      memory_bits <= memory_bits + 1;
    end
    if (memory_shift && memory_select) begin
      memory_word <= {memory_word[14:0], serial_data};
    end
    if (dac_shift) begin
      dac_bits <= dac_bits + 1;
    end
  end
endmodule
`default_nettype wire

// File: daq_command_register_tb.sv
`default_nettype none
module daq_command_register_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK, RSTN, WR_EN, START_STROBE, EXT_N, BUS_TRIG;
  logic SEQ_DONE, ACK, CONV_REQ, CONV_GO, ACQ_TRIGGER, IN_PROG;
  logic SEL, SDAT, SCLK, MSHIFT, DSHIFT, SEQ_CNT, DITHER, SCAN, OE;
  logic INTV, WIDE;
  logic [4:0] WR_ADDR;
  logic [15:0] WR_DATA;
  logic [1:0] DAC_LOAD;
  logic [7:0] DAC0, DAC1;
  int mismatches = 0;
  int compares = 0;
  daq_command_register dut_u (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .WR_EN(WR_EN), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
    .CAL_DAC_LOAD(DAC_LOAD), .START_STROBE(START_STROBE),
    .EXTERNAL_TRIGGER_IN_N(EXT_N), .BUS_TRIGGER_IN(BUS_TRIG),
    .SEQUENCE_DONE(SEQ_DONE), .PROGRESS_ACK(ACK), .CONVERT_REQ(CONV_REQ),
    .CAL_MEMORY_SELECT(SEL), .SERIAL_DATA_BIT(SDAT), .SERIAL_CLOCK(SCLK),
    .MEMORY_SHIFT_PULSE(MSHIFT), .DAC_SHIFT_PULSE(DSHIFT),
    .CAL_DAC0_VALUE(DAC0), .CAL_DAC1_VALUE(DAC1),
    .SEQUENCE_BY_COUNTER(SEQ_CNT), .DITHER_ENABLE(DITHER),
    .CONVERT_GO(CONV_GO), .ACQ_TRIGGER(ACQ_TRIGGER),
    .ACQUISITION_IN_PROGRESS(IN_PROG), .SCAN_ACTIVE(SCAN),
    .SCAN_CLOCK_OUT_OE(OE), .INTERVAL_SCAN(INTV), .WIDE_COUNT_SELECT(WIDE));
  cal_serial_model model_u (.clk(CORE_CLK), .memory_select(SEL),
    .serial_data(SDAT), .memory_shift(MSHIFT), .dac_shift(DSHIFT));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  task automatic tick();
    @(posedge CORE_CLK);
    #1;
  endtask
  task automatic end_sim();
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write strobe drops for a cycle so back-to-back calls stay clean
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    WR_ADDR = a;
    WR_DATA = d;
    WR_EN = 1'b1;
    tick();
    WR_EN = 1'b0;
    tick();
  endtask
  // Bounded look for a trigger pulse; a missing one ends the run
  task automatic trig(input int n, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      if (ACQ_TRIGGER === 1'b1) seen = 1'b1;
      tick();
    end
    chk(16'(seen), 16'(exp));
    if (exp && !seen) end_sim();
  endtask
  function automatic logic [15:0] fields();
    return {10'h000, SEQ_CNT, DITHER, SCAN, OE, INTV, WIDE};
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic fields_and_reset();
    wr(5'h00, 16'h19e0);
    wr(5'h01, 16'h0000);
    chk(fields(), 16'h003f);
    RSTN = 1'b0;
    repeat (3) tick();
    RSTN = 1'b1;
    tick();
    chk(fields(), 16'h003f);
    wr(5'h00, 16'h0080);
    chk(fields(), 16'h0004);
  endtask
  task automatic serial_load();
    logic [7:0] w;
    w = 8'ha5;
    wr(5'h00, 16'h0000);
    wr(5'h00, 16'h2000);
    wr(5'h00, 16'h0000);
    chk(16'(model_u.memory_bits), 16'h0000);
    for (int i = 7; i >= 0; i--) begin
      wr(5'h00, {1'b1, w[i], 14'h0000});
      wr(5'h00, {1'b1, w[i], 1'b1, 13'h0000});
    end
    chk(16'({SEL, SDAT, SCLK}), 16'h0007);
    wr(5'h00, 16'h0000);
    chk(model_u.memory_word, 16'h00a5);
    chk(16'(model_u.dac_bits), 16'h0009);
    chk({DAC1, DAC0}, 16'h0000);
    DAC_LOAD = 2'h1;
    tick();
    DAC_LOAD = 2'h0;
    tick();
    chk({DAC1, DAC0}, 16'h00a5);
    DAC_LOAD = 2'h2;
    tick();
    DAC_LOAD = 2'h0;
    tick();
    chk({DAC1, DAC0}, 16'ha5a5);
  endtask
  task automatic convert_gate(input logic [15:0] cmd, input logic exp);
    wr(5'h00, cmd);
    CONV_REQ = 1'b1;
    tick();
    CONV_REQ = 1'b0;
    chk(16'(CONV_GO), 16'(exp));
  endtask
  task automatic pulse_start(input int n, input logic exp);
    START_STROBE = 1'b1;
    tick();
    START_STROBE = 1'b0;
    trig(n, exp);
  endtask
  task automatic end_seq();
    SEQ_DONE = 1'b1;
    tick();
    SEQ_DONE = 1'b0;
    tick();
  endtask
  task automatic triggers();
    wr(5'h00, 16'h0000);
    pulse_start(4, 1'b0);
    wr(5'h00, 16'h0300);
    pulse_start(1, 1'b1);
    end_seq();
    pulse_start(4, 1'b0);
    chk(16'(IN_PROG), 16'h0001);
    ACK = 1'b1;
    tick();
    ACK = 1'b0;
    chk(16'(IN_PROG), 16'h0000);
    pulse_start(1, 1'b1);
    end_seq();
    wr(5'h00, 16'h0110);
    pulse_start(4, 1'b0);
    EXT_N = 1'b0;
    trig(8, 1'b0);
    EXT_N = 1'b1;
    BUS_TRIG = 1'b1;
    trig(8, 1'b1);
    end_seq();
    wr(5'h00, 16'h0100);
    EXT_N = 1'b0;
    trig(8, 1'b1);
  endtask
  initial begin
    {RSTN, WR_EN, START_STROBE, BUS_TRIG, SEQ_DONE, ACK, CONV_REQ} = '0;
    EXT_N = 1'b1;
    WR_ADDR = 5'h00;
    WR_DATA = 16'h0000;
    DAC_LOAD = 2'h0;
    repeat (16) tick();
    RSTN = 1'b1;
    fields_and_reset();
    serial_load();
    convert_gate(16'h0000, 1'b1);
    convert_gate(16'h0400, 1'b0);
    triggers();
    end_sim();
  end
endmodule
`default_nettype wire
